// ---- core/pciarb_prio.sv ----
// Fixed-priority one-hot picker, lowest index wins
`timescale 1ns/1ps
`default_nettype none

module pciarb_prio #(
    parameter int unsigned WIDTH = 5
) (
    input wire logic [WIDTH-1:0] req_in,
    output logic [WIDTH-1:0] pick_out,
    output logic any_out
);

    always_comb begin
        logic found;
        found = 1'b0;
        pick_out = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (req_in[i] && !found) begin
                pick_out[i] = 1'b1;
                found = 1'b1;
            end
        end
        any_out = found;
    end

endmodule : pciarb_prio

`default_nettype wire

// ---- core/pciarb_sync.sv ----
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pciarb_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;

    // First stage feeds only the second
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1_q <= INIT;
            stage2_q <= INIT;
            stage3_q <= INIT;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_out <= INIT;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_q[i] == stage3_q[i]) begin
                    sync_out[i] <= stage3_q[i];
                end
            end
        end
    end

endmodule : pciarb_sync

`default_nettype wire

// ---- core/pciarb_top.sv ----
// Central PCI arbiter with power-up disable strap and external-arbiter pin roles
`timescale 1ns/1ps
`default_nettype none

module pciarb_top (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // PCI request pins, active low; 0 and 1 double as grant inputs when disabled
    input wire logic [pciarb_pkg::REQ_PINS-1:0] pci_req_n_in,
    // PCI grant pins 0..2, active low; take other roles when disabled
    output logic [pciarb_pkg::GNT_LOW_PINS-1:0] pci_gnt_n_out,
    // Grant-3 pin, also the power-up strap
    input wire logic gnt3_n_in,
    output logic gnt3_n_out,
    output logic gnt3_oe_out,
    // Shared grant/busy line to the host bridge, active low
    input wire logic bridge_grant_busy_line_in,
    output logic bridge_grant_busy_line_out,
    output logic bridge_grant_busy_line_oe_out,
    // Internal side
    input wire logic dma_bus_req_in,
    input wire logic usb_bus_req_in,
    input wire logic usb_split_arb_in,
    input wire logic rtc_square_wave_in,
    output logic dev_bus_owned_out,
    output logic usb_bus_owned_out,
    output logic arbiter_disabled_out,
    output logic strap_valid_out
);

    pciarb_pkg::pciarb_state_type state_q;
    pciarb_pkg::pciarb_state_type state_d;

    logic [pciarb_pkg::REQ_PINS-1:0] req_sync_n;
    logic busy_line_sync_n;
    logic strap_sync;
    logic rtc_sync;

    logic arbiter_disable_strap_q;
    logic strap_done_q;
    logic [pciarb_pkg::CNT_W-1:0] settle_cnt_q;
    logic [pciarb_pkg::CNT_W-1:0] watch_cnt_q;
    logic [pciarb_pkg::REQUESTERS-1:0] owner_q;

    logic [pciarb_pkg::REQUESTERS-1:0] req_vec;
    logic [pciarb_pkg::REQUESTERS-1:0] pick;
    logic any_req;
    logic owner_still_req;
    logic watch_seen;
    logic watch_last;

    logic primary_bus_grant_n;
    logic secondary_bus_grant_n;
    logic primary_bus_request_n;
    logic secondary_bus_request_n;
    logic rtc_square_wave_q;

    // Pin inputs from outside the clock domain
    pciarb_sync #(
        .WIDTH(pciarb_pkg::REQ_PINS),
        .INIT(pciarb_pkg::REQ_IDLE_N)
    ) u_req_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in(pci_req_n_in),
        .sync_out(req_sync_n)
    );

    pciarb_sync #(
        .WIDTH(3),
        .INIT(3'h7)
    ) u_misc_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in({bridge_grant_busy_line_in, gnt3_n_in, rtc_square_wave_in}),
        .sync_out({busy_line_sync_n, strap_sync, rtc_sync})
    );

    // Strap capture after release; the pin floats until then
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle_cnt_q <= '0;
            strap_done_q <= 1'b0;
            arbiter_disable_strap_q <= 1'b0;
        end else if (!strap_done_q) begin
            if (settle_cnt_q == pciarb_pkg::CNT_W'(pciarb_pkg::STRAP_SETTLE_CLKS - 1)) begin
                strap_done_q <= 1'b1;
                arbiter_disable_strap_q <= ~strap_sync;
            end else begin
                settle_cnt_q <= settle_cnt_q + pciarb_pkg::CNT_W'(1);
            end
        end
    end

    // Requests for the internal arbiter; the device itself ranks last
    always_comb begin
        req_vec = pciarb_pkg::OWNER_NONE;
        req_vec[pciarb_pkg::REQ0_POS] = ~req_sync_n[pciarb_pkg::REQ0_POS];
        req_vec[pciarb_pkg::REQ1_POS] = ~req_sync_n[pciarb_pkg::REQ1_POS];
        req_vec[pciarb_pkg::REQ2_POS] = ~req_sync_n[pciarb_pkg::REQ2_POS];
        req_vec[pciarb_pkg::REQ3_POS] = ~req_sync_n[pciarb_pkg::REQ3_POS];
        req_vec[pciarb_pkg::DEV_SLOT] = dma_bus_req_in | usb_bus_req_in;
    end

    pciarb_prio #(
        .WIDTH(pciarb_pkg::REQUESTERS)
    ) u_prio (
        .req_in(req_vec),
        .pick_out(pick),
        .any_out(any_req)
    );

    assign owner_still_req = |(owner_q & req_vec);
    // Line counts as seen high only after our own drive has crossed the synchroniser
    assign watch_seen = watch_cnt_q >= pciarb_pkg::CNT_W'(pciarb_pkg::SYNC_DELAY_CLKS);
    assign watch_last = watch_cnt_q == pciarb_pkg::CNT_W'(pciarb_pkg::WATCH_CLKS - 1);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pciarb_pkg::ST_STRAP: begin
                if (strap_done_q) begin
                    state_d = arbiter_disable_strap_q ? pciarb_pkg::ST_EXTERN : pciarb_pkg::ST_BRIDGE;
                end
            end
            pciarb_pkg::ST_BRIDGE: begin
                if (any_req) begin
                    state_d = pciarb_pkg::ST_RELEASE;
                end
            end
            pciarb_pkg::ST_RELEASE: begin
                state_d = pciarb_pkg::ST_WATCH;
            end
            pciarb_pkg::ST_WATCH: begin
                if (watch_seen && !busy_line_sync_n) begin
                    state_d = pciarb_pkg::ST_BUSY;
                end else if (watch_last) begin
                    state_d = any_req ? pciarb_pkg::ST_GRANT : pciarb_pkg::ST_BRIDGE;
                end
            end
            pciarb_pkg::ST_BUSY: begin
                // Nobody else is granted while the bridge holds the line
                if (busy_line_sync_n) begin
                    state_d = any_req ? pciarb_pkg::ST_GRANT : pciarb_pkg::ST_BRIDGE;
                end
            end
            pciarb_pkg::ST_GRANT: begin
                if (!owner_still_req) begin
                    state_d = pciarb_pkg::ST_GAP;
                end
            end
            pciarb_pkg::ST_GAP: begin
                state_d = any_req ? pciarb_pkg::ST_GRANT : pciarb_pkg::ST_BRIDGE;
            end
            pciarb_pkg::ST_EXTERN: begin
                // Held until the next power-up reset
                state_d = pciarb_pkg::ST_EXTERN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= pciarb_pkg::ST_STRAP;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            watch_cnt_q <= '0;
        end else if (state_q == pciarb_pkg::ST_WATCH) begin
            watch_cnt_q <= watch_cnt_q + pciarb_pkg::CNT_W'(1);
        end else begin
            watch_cnt_q <= '0;
        end
    end

    // Winner is latched on entry so a new arrival cannot split a grant
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            owner_q <= pciarb_pkg::OWNER_NONE;
        end else if (state_d == pciarb_pkg::ST_GRANT && state_q != pciarb_pkg::ST_GRANT) begin
            owner_q <= pick;
        end else if (state_d != pciarb_pkg::ST_GRANT) begin
            owner_q <= pciarb_pkg::OWNER_NONE;
        end
    end

    // Roles of the shared pins while an external arbiter rules the bus
    assign primary_bus_grant_n = req_sync_n[pciarb_pkg::REQ0_POS];
    assign secondary_bus_grant_n = req_sync_n[pciarb_pkg::REQ1_POS] | ~usb_split_arb_in;

    // Without split arbitration the USB cycles go out on the primary request
    always_comb begin
        primary_bus_request_n = ~(dma_bus_req_in | (usb_bus_req_in & ~usb_split_arb_in));
        secondary_bus_request_n = ~(usb_bus_req_in & usb_split_arb_in);
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rtc_square_wave_q <= 1'b0;
        end else begin
            rtc_square_wave_q <= rtc_sync;
        end
    end

    // Grant pins: a single owner bit can be set, so at most one grant is low while the arbiter is on; in ST_EXTERN 0/1 carry the requests, 2 the square wave
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pci_gnt_n_out <= pciarb_pkg::GNT_IDLE_N;
        end else if (state_q == pciarb_pkg::ST_EXTERN) begin
            pci_gnt_n_out[pciarb_pkg::GNT0_POS] <= primary_bus_request_n;
            pci_gnt_n_out[pciarb_pkg::GNT1_POS] <= secondary_bus_request_n;
            pci_gnt_n_out[pciarb_pkg::GNT2_POS] <= rtc_square_wave_q;
        end else if (state_d == pciarb_pkg::ST_GRANT) begin
            pci_gnt_n_out[pciarb_pkg::GNT0_POS] <= ~owner_grant(pciarb_pkg::REQ0_POS);
            pci_gnt_n_out[pciarb_pkg::GNT1_POS] <= ~owner_grant(pciarb_pkg::REQ1_POS);
            pci_gnt_n_out[pciarb_pkg::GNT2_POS] <= ~owner_grant(pciarb_pkg::REQ2_POS);
        end else begin
            pci_gnt_n_out <= pciarb_pkg::GNT_IDLE_N;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gnt3_n_out <= 1'b1;
            gnt3_oe_out <= 1'b0;
        end else if (state_d == pciarb_pkg::ST_STRAP || state_d == pciarb_pkg::ST_EXTERN) begin
            // Floats while strapping and once the arbiter is off
            gnt3_n_out <= 1'b1;
            gnt3_oe_out <= 1'b0;
        end else begin
            gnt3_n_out <= ~(state_d == pciarb_pkg::ST_GRANT && owner_grant(pciarb_pkg::REQ3_POS));
            gnt3_oe_out <= 1'b1;
        end
    end

    // Bridge line: driven low in ST_BRIDGE, high for one clock in ST_RELEASE, left floating in every other state
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bridge_grant_busy_line_out <= 1'b1;
            bridge_grant_busy_line_oe_out <= 1'b0;
        end else begin
            unique case (state_d)
                pciarb_pkg::ST_BRIDGE: begin
                    bridge_grant_busy_line_out <= 1'b0;
                    bridge_grant_busy_line_oe_out <= 1'b1;
                end
                pciarb_pkg::ST_RELEASE: begin
                    bridge_grant_busy_line_out <= 1'b1;
                    bridge_grant_busy_line_oe_out <= 1'b1;
                end
                default: begin
                    bridge_grant_busy_line_out <= 1'b1;
                    bridge_grant_busy_line_oe_out <= 1'b0;
                end
            endcase
        end
    end

    // Ownership seen by the internal masters
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dev_bus_owned_out <= 1'b0;
            usb_bus_owned_out <= 1'b0;
        end else if (state_q == pciarb_pkg::ST_EXTERN) begin
            // External arbiter hands over the bus; depends on its presence
            dev_bus_owned_out <= ~primary_bus_grant_n & dma_bus_req_in;
            usb_bus_owned_out <= usb_split_arb_in ? ~secondary_bus_grant_n
                                                   : ~primary_bus_grant_n & usb_bus_req_in;
        end else begin
            dev_bus_owned_out <= state_d == pciarb_pkg::ST_GRANT && owner_grant(pciarb_pkg::DEV_SLOT)
                                 && dma_bus_req_in;
            usb_bus_owned_out <= state_d == pciarb_pkg::ST_GRANT && owner_grant(pciarb_pkg::DEV_SLOT)
                                 && usb_bus_req_in && !dma_bus_req_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            arbiter_disabled_out <= 1'b0;
            strap_valid_out <= 1'b0;
        end else begin
            arbiter_disabled_out <= arbiter_disable_strap_q;
            strap_valid_out <= strap_done_q;
        end
    end

    // Owner bit lookup; the owner is kept only for the cycle grant is entered or held
    function automatic logic owner_grant(input int unsigned slot);
        logic [pciarb_pkg::REQUESTERS-1:0] sel;
        sel = (state_q == pciarb_pkg::ST_GRANT) ? owner_q : pick;
        return sel[slot];
    endfunction : owner_grant

endmodule : pciarb_top

`default_nettype wire

// ---- include/pciarb_pkg.sv ----
// Package of constants and types shared by the PCI arbiter files
package pciarb_pkg;

    // Pin counts
    localparam int unsigned REQ_PINS = 4;
    localparam int unsigned GNT_LOW_PINS = 3;
    // Requesters seen by the internal arbiter: four external plus the device itself
    localparam int unsigned REQUESTERS = 5;
    localparam int unsigned DEV_SLOT = 4;

    // Request pin positions
    localparam int unsigned REQ0_POS = 0;
    localparam int unsigned REQ1_POS = 1;
    localparam int unsigned REQ2_POS = 2;
    localparam int unsigned REQ3_POS = 3;

    // Grant pin positions on the low grant group
    localparam int unsigned GNT0_POS = 0;
    localparam int unsigned GNT1_POS = 1;
    localparam int unsigned GNT2_POS = 2;

    // Synchroniser depth seen by the arbiter (three flops plus agreement stage, less the release clock)
    localparam int unsigned SYNC_DELAY_CLKS = 3;
    // Bridge may reassert the shared line within this many clocks of seeing it high
    localparam int unsigned BUSY_WINDOW_CLKS = 2;
    localparam int unsigned WATCH_CLKS = SYNC_DELAY_CLKS + BUSY_WINDOW_CLKS;
    // Cycles after reset release before the strap is taken
    localparam int unsigned STRAP_SETTLE_CLKS = 6;
    localparam int unsigned CNT_W = 4;

    // Reset levels
    localparam logic [REQ_PINS-1:0] REQ_IDLE_N = 4'hf;
    localparam logic [GNT_LOW_PINS-1:0] GNT_IDLE_N = 3'h7;
    localparam logic [REQUESTERS-1:0] OWNER_NONE = 5'h00;

    typedef enum logic [2:0] {
        ST_STRAP,
        ST_BRIDGE,
        ST_RELEASE,
        ST_WATCH,
        ST_BUSY,
        ST_GRANT,
        ST_GAP,
        ST_EXTERN
    } pciarb_state_type;

endpackage : pciarb_pkg

// ---- verification/pciarb_partner.sv ----
// Far-side model: PCI masters, external arbiter, host bridge
`timescale 1ns/1ps
`default_nettype none

module pciarb_partner (
    input wire logic clk_in,
    input wire logic ext_in,
    input wire logic [3:0] want_in,
    input wire logic [3:0] gnt_n_in,
    input wire logic [2:0] dly_in,
    input wire logic bw_in,
    input wire logic line_in,
    output logic [3:0] req_n_out = 4'hf,
    output logic bl_out = 1'b0
);
    logic [3:0] done_q = 4'h0;
    logic [7:0] prim_q = 8'hff;
    logic [7:0] sec_q = 8'hff;
    int cnt[4] = '{0, 0, 0, 0};
    always @(negedge clk_in) begin
        prim_q <= {prim_q[6:0], gnt_n_in[0]};
        sec_q <= {sec_q[6:0], gnt_n_in[1]};
        // Bridge grabs the line only after seeing it released
        bl_out <= bw_in & (line_in | bl_out);
        for (int i = 0; i < 4; i++) begin
            cnt[i] = (want_in[i] && !gnt_n_in[i]) ? cnt[i] + 1 : (want_in[i] ? cnt[i] : 0);
            done_q[i] <= want_in[i] & (cnt[i] > 5);
        end
        if (ext_in) begin
            req_n_out[0] <= prim_q[dly_in];
            req_n_out[1] <= sec_q[dly_in];
            // Unused pins toggle so a leak shows up
            req_n_out[3:2] <= req_n_out[3:2] + 2'h1;
        end else begin
            req_n_out <= ~(want_in & ~done_q);
        end
    end
endmodule : pciarb_partner
`default_nettype wire

// ---- verification/pciarb_properties.sv ----
// Port-level assertions for the PCI arbiter
`timescale 1ns/1ps
`default_nettype none

module pciarb_properties (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [pciarb_pkg::REQ_PINS-1:0] pci_req_n_in,
    input wire logic [pciarb_pkg::GNT_LOW_PINS-1:0] pci_gnt_n_out,
    input wire logic gnt3_n_in,
    input wire logic gnt3_n_out,
    input wire logic gnt3_oe_out,
    input wire logic bridge_grant_busy_line_in,
    input wire logic bridge_grant_busy_line_out,
    input wire logic bridge_grant_busy_line_oe_out,
    input wire logic dma_bus_req_in,
    input wire logic usb_bus_req_in,
    input wire logic usb_split_arb_in,
    input wire logic rtc_square_wave_in,
    input wire logic dev_bus_owned_out,
    input wire logic usb_bus_owned_out,
    input wire logic arbiter_disabled_out,
    input wire logic strap_valid_out
);
    logic en;
    logic off;
    logic [3:0] gv;
    logic [5:0] rtc_q;
    logic [3:0] busy_q;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    assign en = strap_valid_out & ~arbiter_disabled_out;
    assign off = strap_valid_out & arbiter_disabled_out;
    // Undriven grant-3 pin counts as no grant
    assign gv = {gnt3_n_out | ~gnt3_oe_out, pci_gnt_n_out};
    // History wide enough to cover the input synchroniser
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rtc_q <= 6'h00;
        end else begin
            rtc_q <= {rtc_q[4:0], rtc_square_wave_in};
        end
    end
    // Cycles the bridge alone has held the line low
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_q <= 4'h0;
        end else if (bridge_grant_busy_line_in || bridge_grant_busy_line_oe_out) begin
            busy_q <= 4'h0;
        end else if (busy_q != 4'hf) begin
            busy_q <= busy_q + 4'h1;
        end
    end
    sequence s_release;
        bridge_grant_busy_line_oe_out && bridge_grant_busy_line_out;
    endsequence
    sequence s_float;
        !bridge_grant_busy_line_oe_out [*5];
    endsequence
    a_one_grant: assert property (en |-> $onehot0(~gv))
        else $error("several grants at once");
    a_grant_gap: assert property (en && |(gv & ~$past(gv)) |-> gv == 4'hf)
        else $error("grant handed over without gap");
    a_grant_cause: assert property (en |-> (~gv & $past(gv) & $past(pci_req_n_in, 4)) == 4'h0)
        else $error("grant without request");
    a_strap_held: assert property (strap_valid_out && $past(strap_valid_out) |-> $stable(arbiter_disabled_out))
        else $error("strap result changed");
    a_release_pulse: assert property (s_release |=> s_float)
        else $error("bridge line not floated after pulse");
    a_busy_blocks: assert property (en && busy_q >= 4'h6 |-> gv == 4'hf)
        else $error("grant while bridge busy");
    a_primary_follow: assert property (off && $past(off) |->
        pci_gnt_n_out[0] == ~$past(dma_bus_req_in | usb_bus_req_in & ~usb_split_arb_in))
        else $error("primary request wrong");
    a_secondary_follow: assert property (off && $past(off) |->
        pci_gnt_n_out[1] == ~$past(usb_bus_req_in & usb_split_arb_in))
        else $error("secondary request wrong");
    a_square_wave: assert property (off && $changed(pci_gnt_n_out[2]) |->
        (pci_gnt_n_out[2] ? |rtc_q : !(&rtc_q)))
        else $error("square wave pin moved alone");
endmodule : pciarb_properties

bind pciarb_top pciarb_properties u_props (.sys_clk_in, .rst_in, .pci_req_n_in, .pci_gnt_n_out,
    .gnt3_n_in, .gnt3_n_out, .gnt3_oe_out, .bridge_grant_busy_line_in, .bridge_grant_busy_line_out,
    .bridge_grant_busy_line_oe_out, .dma_bus_req_in, .usb_bus_req_in, .usb_split_arb_in,
    .rtc_square_wave_in, .dev_bus_owned_out, .usb_bus_owned_out, .arbiter_disabled_out, .strap_valid_out);
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the PCI arbiter
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] pci_req_n_in;
    logic [2:0] pci_gnt_n_out;
    logic gnt3_n_out, gnt3_oe_out, bridge_grant_busy_line_out, bridge_grant_busy_line_oe_out;
    logic dev_bus_owned_out, usb_bus_owned_out, arbiter_disabled_out, strap_valid_out;
    logic dma_bus_req_in = 1'b0, usb_bus_req_in = 1'b0, usb_split_arb_in = 1'b0, rtc_square_wave_in = 1'b0;
    logic strap_pull = 1'b1, ext_mode = 1'b0, bridge_want = 1'b0, bridge_low, gnt3_pin, line, owned_q = 1'b0;
    logic [3:0] want = 4'h0, gv, gv_q = 4'hf;
    logic [2:0] dly = 3'h0;
    int err_count = 0, comparisons = 0, seed = 32'h486428cd, n;
    int exp_q[$], got[$];

    // Wire levels: pulled-up bridge line, strap pull on grant-3
    assign gnt3_pin = (gnt3_oe_out === 1'b1) ? gnt3_n_out : strap_pull;
    assign line = (bridge_grant_busy_line_oe_out === 1'b1) ? bridge_grant_busy_line_out : ~bridge_low;
    assign gv = {gnt3_oe_out === 1'b1 ? gnt3_n_out : 1'b1, pci_gnt_n_out};

    pciarb_top dut (.sys_clk_in, .rst_in, .pci_req_n_in, .pci_gnt_n_out, .gnt3_n_in(gnt3_pin),
        .gnt3_n_out, .gnt3_oe_out, .bridge_grant_busy_line_in(line), .bridge_grant_busy_line_out,
        .bridge_grant_busy_line_oe_out, .dma_bus_req_in, .usb_bus_req_in, .usb_split_arb_in,
        .rtc_square_wave_in, .dev_bus_owned_out, .usb_bus_owned_out, .arbiter_disabled_out, .strap_valid_out);

    pciarb_partner far (.clk_in(sys_clk_in), .ext_in(ext_mode), .want_in(want), .gnt_n_in(gv), .dly_in(dly),
        .bw_in(bridge_want), .line_in(line), .req_n_out(pci_req_n_in), .bl_out(bridge_low));

    initial begin
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // Record grants in the order they appear
    always @(negedge sys_clk_in) begin
        if (rst_in === 1'b0 && strap_valid_out === 1'b1 && arbiter_disabled_out === 1'b0) begin
            for (int i = 0; i < 4; i++) begin
                if (gv_q[i] === 1'b1 && gv[i] === 1'b0) begin
                    got.push_back(i);
                end
            end
            if (owned_q === 1'b0 && dev_bus_owned_out === 1'b1) begin
                got.push_back(4);
            end
        end
        gv_q <= gv;
        owned_q <= dev_bus_owned_out;
    end

    task automatic stop_test();
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset(input logic strap);
        @(negedge sys_clk_in);
        rst_in = 1'b1;
        strap_pull = strap;
        ext_mode = ~strap;
        repeat (16) @(negedge sys_clk_in);
        rst_in = 1'b0;
        repeat (40) @(negedge sys_clk_in);
        check("strap valid", 8'h01, 8'(strap_valid_out));
        check("arbiter off", 8'(!strap), 8'(arbiter_disabled_out));
    endtask : do_reset

    // Simultaneous requests: fixed priority, lowest index first, device last
    task automatic run_round(input logic [3:0] m, input logic d, input logic busy);
        exp_q = {};
        got = {};
        for (int i = 0; i < 5; i++) begin
            if (i < 4 ? m[i] : d) begin
                exp_q.push_back(i);
            end
        end
        bridge_want = busy;
        want = m;
        dma_bus_req_in = d;
        for (n = 0; n < 900 && (got.size() < exp_q.size() || (busy && n <= 60)); n++) begin
            @(negedge sys_clk_in);
            if (n == 60 && busy) begin
                check("busy grants", 8'h00, 8'(got.size()));
                bridge_want = 1'b0;
            end
            if (dev_bus_owned_out === 1'b1) begin
                dma_bus_req_in = 1'b0;
            end
        end
        want = 4'h0;
        if (n == 900) begin
            err_count++;
            stop_test();
        end
        foreach (exp_q[k]) check("grant order", 8'(exp_q[k]), 8'(got[k]));
        repeat (30) @(negedge sys_clk_in);
    endtask : run_round

    initial begin
        do_reset(1'b1);
        check("line driven", 8'h02, 8'({bridge_grant_busy_line_oe_out, bridge_grant_busy_line_out}));
        for (int i = 0; i < 4; i++) run_round(4'(1 << i), 1'b0, 1'b0);
        run_round(4'hf, 1'b1, 1'b0);
        repeat (6) run_round(4'($random(seed)), 1'($random(seed)), 1'b0);
        run_round(4'h4, 1'b0, 1'b1);
        // Internal USB host takes the device slot while the arbiter is on
        usb_bus_req_in = 1'b1;
        for (n = 0; n < 40 && usb_bus_owned_out !== 1'b1; n++) begin
            @(negedge sys_clk_in);
        end
        check("usb owned", 8'h01, 8'({dev_bus_owned_out, usb_bus_owned_out}));
        usb_bus_req_in = 1'b0;
        repeat (30) @(negedge sys_clk_in);
        do_reset(1'b0);
        check("grant3 oe", 8'h00, 8'(gnt3_oe_out));
        for (int k = 0; k < 6; k++) begin
            dly = (k < 3) ? 3'h0 : 3'h5;
            usb_split_arb_in = (k % 3 == 1);
            @(negedge sys_clk_in);
            dma_bus_req_in = (k % 3 == 0);
            usb_bus_req_in = (k % 3 != 0);
            @(negedge sys_clk_in);
            check("request pin", 8'h00, 8'(pci_gnt_n_out[usb_split_arb_in]));
            for (n = 0; n < 40 && (dma_bus_req_in ? dev_bus_owned_out : usb_bus_owned_out) !== 1'b1; n++) begin
                @(negedge sys_clk_in);
            end
            check("owned", 8'h01, 8'(dma_bus_req_in ? dev_bus_owned_out : usb_bus_owned_out));
            if (n == 40) begin
                stop_test();
            end
            dma_bus_req_in = 1'b0;
            usb_bus_req_in = 1'b0;
            repeat (20) @(negedge sys_clk_in);
            check("released", 8'h03, 8'({dev_bus_owned_out, usb_bus_owned_out, pci_gnt_n_out[1:0]}));
        end
        repeat (4) begin
            rtc_square_wave_in = 1'($random(seed));
            repeat (8) @(negedge sys_clk_in);
            check("square wave", 8'(rtc_square_wave_in), 8'(pci_gnt_n_out[2]));
        end
        do_reset(1'b1);
        run_round(4'h3, 1'b0, 1'b0);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
